// ===== core/ada_consts.svh
// Purpose: Offsets, reset values and fixed counts of the descriptor address/count block
// Assumes: Included by bare name; definitions only
// Notes: Byte addresses on the register bus, one aligned word per register
`ifndef ADA_CONSTS_SVH
`define ADA_CONSTS_SVH
// ******************************
// Register byte offsets
// ******************************
`define ADA_OFF_GF1 8'h00
`define ADA_OFF_GF2 8'h04
`define ADA_OFF_GF3 8'h08
`define ADA_OFF_GF4 8'h0c
`define ADA_OFF_GF5 8'h10
`define ADA_OFF_DEST 8'h14
`define ADA_OFF_COUNT 8'h18
`define ADA_OFF_CTRL 8'h1c
`define ADA_OFF_WBASE 8'h20
`define ADA_OFF_WLIMIT 8'h24
`define ADA_OFF_FILL 8'h28
`define ADA_OFF_STAT 8'h2c
// ******************************
// Fields, resets, counts
// ******************************
`define ADA_CTRL_WEN 0
`define ADA_CTRL_W64 1
`define ADA_RST_WORD 32'h0000_0000
`define ADA_RST_COUNT 24'h00_0000
`define ADA_RST_BYTE 8'h00
`define ADA_BEAT_BYTES 4'h8
`define ADA_GF_POLY 8'h1d
`define ADA_RESP_OKAY 2'b00
`define ADA_RESP_SLVERR 2'b10
`endif

// ===== core/ada_pkg.sv
// Purpose: Types shared by the descriptor address/count block
// Assumes: Constants live in ada_consts.svh
// Notes: Nothing here is imported; users write ada_pkg::name
package ada_pkg;
  typedef enum logic [1:0] {ADA_IDLE = 2'b00, ADA_WAIT = 2'b01, ADA_ISSUE = 2'b10} ada_state_t;
  typedef enum logic [1:0] {ADA_OP_XFER = 2'b00, ADA_OP_DXOR = 2'b01, ADA_OP_FILL = 2'b10} ada_op_t;
  typedef struct packed {
    ada_state_t state; ada_op_t op; logic dp_en; logic [31:0] dest; logic [23:0] count;
    logic [4:0][31:0] gf; logic [31:0] fill; logic [1:0] win_ctrl; logic [31:0] win_base;
    logic [31:0] win_limit; logic wr_valid; logic [31:0] wr_addr; logic [63:0] wr_data;
    logic [7:0] wr_be; logic [3:0] wr_n; logic wr_pci; logic wr_pci64;
  } ada_core_t;
  typedef struct packed {
    logic aw_got; logic w_got; logic [7:0] awaddr; logic [31:0] wdata; logic [3:0] wstrb;
    logic bvalid; logic [1:0] bresp; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } ada_axil_t;
  typedef struct packed {
    logic valid; logic [63:0] data;
  } ada_gf_t;
endpackage

// ===== core/ada_reg_if.sv
// Purpose: Register access path between bus slave and register file
// Assumes: Single clock, strobes valid for one cycle
// Notes: Read data are combinational from the register side
`timescale 1ns/1ps
`default_nettype none
interface ada_reg_if;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wr_err;
  logic [7:0] rd_addr;
  logic [31:0] rdata;
  logic rd_err;
  modport bus (output wr_stb, wr_addr, wdata, wstrb, rd_addr, input wr_err, rdata, rd_err);
  modport regs (input wr_stb, wr_addr, wdata, wstrb, rd_addr, output wr_err, rdata, rd_err);
endinterface
`default_nettype wire

// ===== core/ada_gf_mul.sv
// Purpose: Galois-field multiply of dual-parity source data by its multiplier byte
// Assumes: One beat of eight bytes per valid, source index 0..15
// Notes: Bypass when dual-parity mode is off; one cycle of latency
`timescale 1ns/1ps
`default_nettype none
`include "ada_consts.svh"
module ada_gf_mul (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  input wire logic valid_i,
  input wire logic [3:0] src_i,
  input wire logic [63:0] data_i,
  input wire logic [127:0] mult_i,
  output logic valid_o,
  output logic [63:0] data_o
);
  ada_pkg::ada_gf_t q, d;
  logic [7:0] m;
  logic [63:0] prod;
  // Shift-and-add multiply, reduced by the field polynomial
  function automatic logic [7:0] gf_mul8(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] x;
    acc = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) acc = acc ^ x;
      x = x[7] ? ({x[6:0], 1'b0} ^ `ADA_GF_POLY) : {x[6:0], 1'b0};
    end
    return acc;
  endfunction
  // Multiplier byte picked by the source register index
  assign m = mult_i[{src_i, 3'b000} +: 8];
  // One multiplier per byte lane
  for (genvar l = 0; l < 8; l++) begin : g_lane
    assign prod[8*l +: 8] = gf_mul8(data_i[8*l +: 8], m);
  end
  // Product only in dual-parity mode
  always_comb begin
    d = q;
    d.valid = valid_i;
    if (valid_i) d.data = en_i ? prod : data_i;
  end
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) q <= '0;
    else q <= d;
  end
  assign valid_o = q.valid;
  assign data_o = q.data;
  chk_gf_bypass_path: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    valid_i && !en_i |=> valid_o && data_o == $past(data_i)) else $error("gf bypass altered data");
endmodule
`default_nettype wire

// ===== core/ada_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the register file
// Assumes: One write and one read outstanding; address and data in any order
// Notes: Write answer one edge after both halves are held; read answer one edge after address
`timescale 1ns/1ps
`default_nettype none
`include "ada_consts.svh"
module ada_axil_slave (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  ada_reg_if.bus rif
);
  ada_pkg::ada_axil_t q, d;
  // Halves are refused while a response is pending, keeping one write in flight
  assign s_axi_awready_o = !q.aw_got && !q.bvalid;
  assign s_axi_wready_o = !q.w_got && !q.bvalid;
  assign s_axi_arready_o = !q.rvalid;
  assign rif.wr_stb = q.aw_got && q.w_got && !q.bvalid;
  assign rif.wr_addr = q.awaddr;
  assign rif.wdata = q.wdata;
  assign rif.wstrb = q.wstrb;
  assign rif.rd_addr = s_axi_araddr_i;
  // Channel bookkeeping
  always_comb begin
    d = q;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata_i;
      d.wstrb = s_axi_wstrb_i;
    end
    if (q.bvalid && s_axi_bready_i) d.bvalid = 1'b0;
    if (rif.wr_stb) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = rif.wr_err ? `ADA_RESP_SLVERR : `ADA_RESP_OKAY;
    end
    if (q.rvalid && s_axi_rready_i) d.rvalid = 1'b0;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      d.rvalid = 1'b1;
      d.rdata = rif.rdata;
      d.rresp = rif.rd_err ? `ADA_RESP_SLVERR : `ADA_RESP_OKAY;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) q <= '0;
    else q <= d;
  end
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_rvalid_o = q.rvalid;
  assign s_axi_rdata_o = q.rdata;
  assign s_axi_rresp_o = q.rresp;
  chk_bresp_hold_stable: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    q.bvalid && !s_axi_bready_i |=> q.bvalid && $stable(q.bresp)) else $error("write answer dropped");
endmodule
`default_nettype wire

// ===== core/ada_desc_regs.sv
// Purpose: Per-descriptor multiplier, destination and byte count registers with the result write engine
// Assumes: Descriptor fields, store queue and write bus all run on mclk_i
// Notes: Registers reached over AXI4-Lite; descriptor fields are read-only to software
//
// Operation
// - Multipliers 1,4,7,10,13 sit in bits 7:0 of words one to five, reset zero.
// - Multipliers 2,5,8,11,14 sit in bits 15:8 of words one to five, reset zero.
// - Multiplier bytes scale matching dual-parity source data only in dual-parity mode.
// - Top byte of words one to four reserved; word five top byte is multiplier 16.
// - Multipliers 3,6,9,12,15 sit in bits 23:16 of words one to five.
// - Destination is a 32-bit byte address targeted by the result writes.
// - Destinations inside the outbound window go to PCI, 32 or 64-bit per window.
// - Dual XOR writes the horizontal result to the destination block.
// - Block fill writes the first data register constant from the destination onward.
// - The fill constant stays unchanged for the whole fill operation.
// - Destination reads return programmed value plus bytes already written.
// - Destination loads from the descriptor and is read-only to software.
// - Byte count is read-only, loaded from the descriptor, up to 16 Mbytes.
// - Zero byte count is valid and causes no bus cycles at all.
// - Count reads give bytes still to write, not counting store queue data.
// - Count drops by one to eight per successful store queue transfer.
// - Count drops by one to eight per successful fill write.
// - Any count alignment is accepted; trailing partial beats are handled.
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ada_consts.svh"
module ada_desc_regs (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic desc_load_i,
  input wire logic [1:0] desc_op_i,
  input wire logic desc_dp_en_i,
  input wire logic [31:0] desc_dest_i,
  input wire logic [23:0] desc_count_i,
  input wire logic [31:0] desc_fill_i,
  input wire logic [159:0] desc_gf_i,
  output logic desc_ready_o,
  input wire logic sq_valid_i,
  input wire logic [63:0] sq_data_i,
  output logic sq_ready_o,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [31:0] wr_addr_o,
  output logic [63:0] wr_data_o,
  output logic [7:0] wr_be_o,
  output logic wr_pci_o,
  output logic wr_pci64_o,
  input wire logic gf_valid_i,
  input wire logic [3:0] gf_src_i,
  input wire logic [63:0] gf_data_i,
  output logic gf_valid_o,
  output logic [63:0] gf_data_o,
  output logic busy_o
);
  // ******************************
  // Declarations
  // ******************************
  ada_pkg::ada_core_t q, d;
  ada_reg_if rif();
  logic [4:0][31:0] gf_in;
  logic [127:0] mult;
  logic [3:0] room;
  logic [3:0] n_c;
  logic [7:0] be_c;
  logic in_win;
  logic wr_take;
  logic desc_take;

  // Byte lanes covered by n bytes starting at lane off
  function automatic logic [7:0] lane_mask(input logic [2:0] off, input logic [3:0] n);
    logic [15:0] m;
    m = 16'h00ff >> (4'h8 - n);
    m = m << off;
    return m[7:0];
  endfunction

  // New data masked in by byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // ******************************
  // Bus slave and multiplier unit
  // ******************************
  ada_axil_slave u_axil (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .rif(rif.bus)
  );

  ada_gf_mul u_gf (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .en_i(q.dp_en),
    .valid_i(gf_valid_i),
    .src_i(gf_src_i),
    .data_i(gf_data_i),
    .mult_i(mult),
    .valid_o(gf_valid_o),
    .data_o(gf_data_o)
  );

  // ******************************
  // Multiplier word layout
  // ******************************
  // Reserved top byte forced to zero at load, so reads always show zero there
  for (genvar w = 0; w < 5; w++) begin : g_word
    if (w == 4) begin : g_top
      assign gf_in[w] = desc_gf_i[32*w +: 32];
    end else begin : g_rsv
      assign gf_in[w] = {`ADA_RST_BYTE, desc_gf_i[32*w +: 24]};
    end
  end

  // Multiplier k+1 lives in word k/3, byte k%3; the sixteenth in word five top byte
  for (genvar k = 0; k < 16; k++) begin : g_mult
    if (k == 15) begin : g_last
      assign mult[8*k +: 8] = q.gf[4][31:24];
    end else begin : g_reg
      assign mult[8*k +: 8] = q.gf[k/3][8*(k%3) +: 8];
    end
  end

  // ******************************
  // Chunking and routing
  // ******************************
  // Never cross an eight-byte beat; the tail beat carries the remainder
  assign room = `ADA_BEAT_BYTES - {1'b0, q.dest[2:0]};
  assign n_c = (q.count < {20'h0_0000, room}) ? q.count[3:0] : room;
  assign be_c = lane_mask(q.dest[2:0], n_c);
  assign in_win = q.win_ctrl[`ADA_CTRL_WEN] && q.dest >= q.win_base && q.dest <= q.win_limit;
  assign wr_take = q.wr_valid && wr_ready_i;
  assign desc_take = desc_load_i && q.state == ada_pkg::ADA_IDLE;
  assign desc_ready_o = q.state == ada_pkg::ADA_IDLE;
  assign busy_o = q.state != ada_pkg::ADA_IDLE;
  // Fill never draws on the store queue
  assign sq_ready_o = q.state == ada_pkg::ADA_WAIT && q.op != ada_pkg::ADA_OP_FILL;

  // ******************************
  // Next state
  // ******************************
  always_comb begin
    d = q;
    // Software reaches only the window controls
    if (rif.wr_stb) begin
      case (rif.wr_addr)
        `ADA_OFF_CTRL: d.win_ctrl = 2'(merge({30'h0, q.win_ctrl}, rif.wdata, rif.wstrb));
        `ADA_OFF_WBASE: d.win_base = merge(q.win_base, rif.wdata, rif.wstrb);
        `ADA_OFF_WLIMIT: d.win_limit = merge(q.win_limit, rif.wdata, rif.wstrb);
        default: ;
      endcase
    end
    case (q.state)
      ada_pkg::ADA_IDLE: begin
        if (desc_load_i) begin
          d.dest = desc_dest_i;
          d.count = desc_count_i;
          d.fill = desc_fill_i;
          d.gf = gf_in;
          d.op = ada_pkg::ada_op_t'(desc_op_i);
          d.dp_en = desc_dp_en_i;
          // Zero count finishes at once with no bus cycle
          if (desc_count_i != `ADA_RST_COUNT) d.state = ada_pkg::ADA_WAIT;
        end
      end
      ada_pkg::ADA_WAIT: begin
        if (q.op == ada_pkg::ADA_OP_FILL || sq_valid_i) begin
          d.wr_valid = 1'b1;
          d.wr_addr = q.dest;
          d.wr_be = be_c;
          d.wr_n = n_c;
          d.wr_pci = in_win;
          d.wr_pci64 = in_win && q.win_ctrl[`ADA_CTRL_W64];
          d.wr_data = (q.op == ada_pkg::ADA_OP_FILL) ? {q.fill, q.fill} : sq_data_i;
          d.state = ada_pkg::ADA_ISSUE;
        end
      end
      ada_pkg::ADA_ISSUE: begin
        // Count and address move only once the write is taken
        if (wr_take) begin
          d.wr_valid = 1'b0;
          d.dest = q.dest + {28'h000_0000, q.wr_n};
          d.count = q.count - {20'h0_0000, q.wr_n};
          d.state = (q.count == {20'h0_0000, q.wr_n}) ? ada_pkg::ADA_IDLE : ada_pkg::ADA_WAIT;
        end
      end
      default: d.state = ada_pkg::ADA_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) q <= '0;
    else q <= d;
  end

  // ******************************
  // Register reads and write checks
  // ******************************
  always_comb begin
    rif.rdata = `ADA_RST_WORD;
    rif.rd_err = 1'b0;
    case (rif.rd_addr)
      `ADA_OFF_GF1: rif.rdata = q.gf[0];
      `ADA_OFF_GF2: rif.rdata = q.gf[1];
      `ADA_OFF_GF3: rif.rdata = q.gf[2];
      `ADA_OFF_GF4: rif.rdata = q.gf[3];
      `ADA_OFF_GF5: rif.rdata = q.gf[4];
      `ADA_OFF_DEST: rif.rdata = q.dest;
      `ADA_OFF_COUNT: rif.rdata = {8'h00, q.count};
      `ADA_OFF_CTRL: rif.rdata = {30'h0000_0000, q.win_ctrl};
      `ADA_OFF_WBASE: rif.rdata = q.win_base;
      `ADA_OFF_WLIMIT: rif.rdata = q.win_limit;
      `ADA_OFF_FILL: rif.rdata = q.fill;
      `ADA_OFF_STAT: rif.rdata = {27'h000_0000, q.op, q.dp_en, 1'b0, busy_o};
      default: rif.rd_err = 1'b1;
    endcase
  end

  // Descriptor registers refuse software writes
  always_comb begin
    case (rif.wr_addr)
      `ADA_OFF_CTRL, `ADA_OFF_WBASE, `ADA_OFF_WLIMIT: rif.wr_err = 1'b0;
      default: rif.wr_err = 1'b1;
    endcase
  end

  // ******************************
  // Outputs
  // ******************************
  assign wr_valid_o = q.wr_valid;
  assign wr_addr_o = q.wr_addr;
  assign wr_data_o = q.wr_data;
  assign wr_be_o = q.wr_be;
  assign wr_pci_o = q.wr_pci;
  assign wr_pci64_o = q.wr_pci64;

  // ******************************
  // Checks
  // ******************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence seq_wr_done;
    q.wr_valid && wr_ready_i;
  endsequence

  sequence seq_load;
    desc_take;
  endsequence

  chk_zero_count_quiet: assert property (seq_load ##0 desc_count_i == 24'h00_0000 |=>
    !busy_o [*3] ##0 !wr_valid_o) else $error("zero count started a write");
  chk_load_dest_count: assert property (seq_load |=>
    q.dest == $past(desc_dest_i) && q.count == $past(desc_count_i)) else $error("descriptor not loaded");
  chk_dest_advance_by: assert property (seq_wr_done |=>
    q.dest == $past(q.dest) + {28'h000_0000, $past(q.wr_n)}) else $error("destination did not advance");
  chk_count_step_size: assert property (seq_wr_done |-> q.wr_n >= 4'h1 && q.wr_n <= 4'h8
    ##1 q.count == $past(q.count) - {20'h0_0000, $past(q.wr_n)}) else $error("byte count step wrong");
  chk_fill_const_hold: assert property (busy_o && !desc_take |=> $stable(q.fill))
    else $error("fill constant changed");
  chk_fill_beat_data: assert property (wr_valid_o && q.op == ada_pkg::ADA_OP_FILL |->
    wr_data_o == {q.fill, q.fill}) else $error("fill data wrong");
  chk_pci_route_window: assert property (q.state == ada_pkg::ADA_WAIT && !sq_ready_o |=>
    wr_pci_o == $past(in_win)) else $error("window routing wrong");
  chk_lanes_match_count: assert property (wr_valid_o |-> $countones(wr_be_o) == q.wr_n &&
    q.wr_n <= q.count[23:0]) else $error("byte lanes disagree with count");
  chk_write_hold_addr: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o &&
    $stable(wr_addr_o) && $stable(wr_data_o)) else $error("write dropped before taken");
  chk_last_write_idle: assert property (seq_wr_done ##0 q.count == {20'h0_0000, q.wr_n} |=>
    !busy_o && q.count == 24'h00_0000) else $error("did not finish at zero");
  chk_rsv_byte_zero: assert property (q.gf[0][31:24] == 8'h00 && q.gf[3][31:24] == 8'h00)
    else $error("reserved multiplier byte set");
  chk_mult_map_low: assert property (mult[31:24] == q.gf[1][7:0] && mult[111:104] == q.gf[4][15:8])
    else $error("multiplier map wrong");
endmodule
`default_nettype wire

// ===== verification/ada_wr_partner.sv
// Purpose: Result write partner, memory controller and outbound path
// Assumes: A write is taken when valid and ready are high
// Notes: Ready stalls at random
`timescale 1ns/1ps
`default_nettype none
module ada_wr_partner (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [31:0] wr_addr_i,
  input wire logic [63:0] wr_data_i,
  input wire logic [7:0] wr_be_i,
  input wire logic wr_pci_i,
  input wire logic wr_pci64_i,
  output logic [15:0] got_o,
  output logic [105:0] last_o
);
  int seed = 7;
  // A third of cycles stall
  always @(posedge mclk_i) begin
    wr_ready_o <= reset_n_i && ($random(seed) % 3 != 0);
    if (!reset_n_i) begin
      got_o <= 16'h0000;
    end else if (wr_valid_i && wr_ready_o) begin
      got_o <= got_o + 16'h0001;
      last_o <= {wr_pci64_i, wr_pci_i, wr_be_i, wr_addr_i, wr_data_i};
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_ada_desc_regs.sv
// Purpose: Self-checking bench for the descriptor address/count block
// Assumes: Partner stalls writes at random
// Notes: Seeded random plus corner cases
`timescale 1ns/1ps
`default_nettype none
`include "ada_consts.svh"
module tb_ada_desc_regs;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b1;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b1, desc_load_i = 1'b0, desc_dp_en_i = 1'b0;
  logic sq_valid_i = 1'b0, gf_valid_i = 1'b0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, wr_be_o, m;
  logic [2:0] s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0;
  logic [31:0] s_axi_wdata_i = 32'h0, desc_dest_i = 32'h0, desc_fill_i = 32'h0, s_axi_rdata_o, wr_addr_o;
  logic [3:0] s_axi_wstrb_i = 4'hf, gf_src_i = 4'h0;
  logic [1:0] desc_op_i = 2'h0, s_axi_bresp_o, s_axi_rresp_o;
  logic [23:0] desc_count_i = 24'h0;
  logic [159:0] desc_gf_i = 160'h0;
  logic [63:0] sq_data_i = 64'h0, gf_data_i = 64'h0, wr_data_o, gf_data_o;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, desc_ready_o;
  logic sq_ready_o, wr_valid_o, wr_ready_i, wr_pci_o, wr_pci64_o, gf_valid_o, busy_o;
  logic [15:0] got;
  logic [105:0] last;
  int miscompares = 0, check_count = 0, seed = 7;
  // ****************
  // Clock, design, partner
  // ****************
  always #2 mclk_i = ~mclk_i;
  ada_desc_regs ada_desc_regs_inst (.*);
  ada_wr_partner ada_wr_partner_inst (.mclk_i, .reset_n_i, .wr_valid_i(wr_valid_o), .wr_ready_o(wr_ready_i),
    .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o), .wr_be_i(wr_be_o), .wr_pci_i(wr_pci_o),
    .wr_pci64_i(wr_pci64_o), .got_o(got), .last_o(last));
  // ****************
  // Tasks and models
  // ****************
  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Handshakes judged at the falling edge; ready is settled there
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    {s_axi_awvalid_i, s_axi_wvalid_i} <= 2'b11;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    do begin
      @(negedge mclk_i);
      ha = s_axi_awvalid_i && s_axi_awready_o;
      hw = s_axi_wvalid_i && s_axi_wready_o;
      hb = s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge mclk_i);
      if (ha) s_axi_awvalid_i <= 1'b0;
      if (hw) s_axi_wvalid_i <= 1'b0;
    end while (!hb);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h, g;
    s_axi_arvalid_i <= 1'b1;
    s_axi_araddr_i <= a;
    do begin
      @(negedge mclk_i);
      h = s_axi_arvalid_i && s_axi_arready_o;
      g = s_axi_rvalid_o;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge mclk_i);
      if (h) s_axi_arvalid_i <= 1'b0;
    end while (!g);
  endtask
  task automatic dload(input logic [1:0] op, input logic p, input logic [31:0] d, input logic [23:0] c);
    desc_load_i <= 1'b1;
    desc_op_i <= op;
    desc_dp_en_i <= p;
    desc_dest_i <= d;
    desc_count_i <= c;
    desc_fill_i <= $random(seed);
    desc_gf_i <= {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    @(posedge mclk_i);
    desc_load_i <= 1'b0;
  endtask
  // Leading edge avoids a double drive; returns once the write is taken
  task automatic beat(input logic [63:0] x);
    logic h;
    @(posedge mclk_i);
    sq_valid_i <= 1'b1;
    sq_data_i <= x;
    do begin
      @(negedge mclk_i);
      h = sq_ready_o;
      @(posedge mclk_i);
    end while (!h);
    sq_valid_i <= 1'b0;
    do @(negedge mclk_i); while (wr_valid_o !== 1'b0);
    @(posedge mclk_i);
  endtask
  task automatic idle();
    do @(negedge mclk_i); while (busy_o !== 1'b0 || wr_valid_o !== 1'b0);
    @(posedge mclk_i);
  endtask
  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p ^= a;
      a = {a[6:0], 1'b0} ^ (a[7] ? `ADA_GF_POLY : 8'h00);
    end
    return p;
  endfunction
  // Lanes, address of last write
  function automatic logic [39:0] tail(input logic [31:0] d, input logic [23:0] c);
    logic [31:0] e, a;
    e = d + c - 1;
    a = (e[31:3] == d[31:3]) ? d : {e[31:3], 3'h0};
    return {8'((9'h2 << e[2:0]) - 9'h1) & ~8'((9'h1 << a[2:0]) - 9'h1), a};
  endfunction
  // ****************
  // Scenarios
  // ****************
  initial begin
    logic [31:0] r, d;
    logic [1:0] e;
    logic [23:0] c;
    logic [63:0] x;
    logic [15:0] g;
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    for (int k = 0; k < 5; k++) begin
      axr(8'(4 * k), r, e);
      chk("gf reset", {e, r}, 34'h0);
    end
    axw(`ADA_OFF_DEST, 32'hffff_ffff, e);
    chk("dest wr resp", e, `ADA_RESP_SLVERR);
    axr(`ADA_OFF_DEST, r, e);
    chk("dest kept", r, 32'h0);
    axr(8'h30, r, e);
    chk("unmapped", {e, r}, {`ADA_RESP_SLVERR, 32'h0});
    // Zero-count loads; product, then bypass
    for (int p = 1; p >= 0; p--) begin
      g = got;
      dload(2'h0, p[0], 32'h0, 24'h0);
      gf_valid_i <= 1'b1;
      gf_src_i <= 4'($random(seed));
      gf_data_i <= {$random(seed), $random(seed)};
      @(posedge mclk_i);
      gf_valid_i <= 1'b0;
      @(negedge mclk_i);
      m = gf_src_i == 4'hf ? desc_gf_i[159:152] : desc_gf_i[32 * (gf_src_i / 3) + 8 * (gf_src_i % 3) +: 8];
      for (int b = 0; b < 8; b++) x[8 * b +: 8] = gm(gf_data_i[8 * b +: 8], p ? m : 8'h01);
      chk("gf out", {gf_valid_o, gf_data_o[62:0]}, {1'b1, x[62:0]});
      chk("gf msb", gf_data_o[63], x[63]);
      repeat (2) @(negedge mclk_i);
      chk("zero count", {busy_o, desc_ready_o, got}, {2'b01, g});
      @(posedge mclk_i);
      for (int k = 0; k < 5; k++) begin
        axr(8'(4 * k), r, e);
        chk("gf word", r, {k == 4 ? desc_gf_i[159:152] : 8'h00, desc_gf_i[32 * k +: 24]});
      end
    end
    // Dual XOR, odd start lane, one-byte tail
    g = got;
    dload(2'h1, 1'b0, 32'h0000_0103, 24'h00_000e);
    beat({$random(seed), $random(seed)});
    axr(`ADA_OFF_COUNT, r, e);
    chk("count mid", r, 32'h9);
    axr(`ADA_OFF_DEST, r, e);
    chk("dest mid", r, 32'h108);
    beat({$random(seed), $random(seed)});
    x = {$random(seed), $random(seed)};
    beat(x);
    idle();
    chk("dxor tail", {got - g, last[103:64]}, {16'h3, 8'h01, 32'h110});
    chk("dxor data", last[63:0], x);
    axr(`ADA_OFF_DEST, r, e);
    chk("dest end", r, 32'h111);
    // Random fills; fill input flips mid-run
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      c = 24'(1 + {$random(seed)} % 20);
      g = got;
      dload(2'h2, 1'b0, d, c);
      r = desc_fill_i;
      desc_fill_i <= ~r;
      idle();
      chk("fill writes", got - g, 16'((d[2:0] + c + 7) / 8));
      chk("fill tail", last[103:64], tail(d, c));
      chk("fill data", last[63:0], {r, r});
      axr(`ADA_OFF_DEST, r, e);
      chk("fill dest", r, d + c);
      axr(`ADA_OFF_COUNT, r, e);
      chk("fill count", r, 32'h0);
    end
    // Window: inside to PCI at its width, outside local
    axw(`ADA_OFF_WBASE, 32'h8000_0000, e);
    axw(`ADA_OFF_WLIMIT, 32'h8000_0fff, e);
    for (int k = 0; k < 3; k++) begin
      axw(`ADA_OFF_CTRL, k == 1 ? 32'h1 : 32'h3, e);
      chk("ctrl resp", e, `ADA_RESP_OKAY);
      dload(2'h2, 1'b0, k == 2 ? 32'h8000_1000 : 32'h8000_0ff8, 24'h8);
      idle();
      chk("pci route", last[105:104], {k == 0, k != 2});
    end
    report_and_stop();
  end
  // Hang guard
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
